// file: rtl/async_tx_pkg.sv
`default_nettype none
package async_tx_pkg;

   // ---------------------------------------------------------------
   // Word layout
   // ---------------------------------------------------------------
   localparam int          DATA_W         = 8;
   localparam int          WORD_W         = 9;
   localparam int          NINTH_POS      = 8;
   localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;

   // ---------------------------------------------------------------
   // Baud timing, counted in baud generator ticks within one bit
   // ---------------------------------------------------------------
   localparam logic [5:0]  LAST_PHASE_STD  = 6'h3F;
   localparam logic [5:0]  LAST_PHASE_FAST = 6'h0F;
   localparam logic [7:0]  BAUD_RESET      = 8'h00;

   // Majority sample points, standard speed: x16 falling edges 7, 8, 9.
   localparam logic [5:0]  SAMPLE_STD_A    = 6'h1A;
   localparam logic [5:0]  SAMPLE_STD_B    = 6'h1E;
   localparam logic [5:0]  SAMPLE_STD_C    = 6'h22;
   // Majority sample points, high speed: three ticks before x4 edge.
   localparam logic [5:0]  SAMPLE_FAST_A   = 6'h05;
   localparam logic [5:0]  SAMPLE_FAST_B   = 6'h06;
   localparam logic [5:0]  SAMPLE_FAST_C   = 6'h07;

   // ---------------------------------------------------------------
   // Reset values and buffer levels
   // ---------------------------------------------------------------
   localparam logic        FLAG_RESET      = 1'b0;
   localparam logic        LINE_IDLE       = 1'b1;
   localparam logic        LINE_START      = 1'b0;
   localparam logic [1:0]  LEVEL_EMPTY     = 2'h0;
   localparam logic [1:0]  LEVEL_ONE       = 2'h1;
   localparam logic [1:0]  LEVEL_FULL      = 2'h2;

   typedef enum {
      TX_IDLE,
      TX_WAIT,
      TX_START,
      TX_DATA,
      TX_NINTH,
      TX_STOP
   } tx_state_t;

endpackage : async_tx_pkg
`default_nettype wire

// file: rtl/word_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if;
   import async_tx_pkg::*;

   logic [WORD_W-1:0] wr_data;
   logic              wr_valid;
   logic              wr_ready;
   logic [WORD_W-1:0] rd_data;
   logic              rd_valid;
   logic              rd_ready;
   logic [1:0]        level;

   modport store (
      input  wr_data, wr_valid, rd_ready,
      output wr_ready, rd_data, rd_valid, level
   );

   modport user (
      output wr_data, wr_valid, rd_ready,
      input  wr_ready, rd_data, rd_valid, level
   );

endinterface : word_stream_if
`default_nettype wire

// file: rtl/tx_word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tx_word_buffer
   import async_tx_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   reset_n_i,
   // Word stream
   word_stream_if.store words
);

   logic [WORD_W-1:0] entry [2];
   logic              wr_ptr;
   logic              rd_ptr;
   logic [1:0]        count;
   logic              push;
   logic              pop;

   assign push           = words.wr_valid & words.wr_ready;
   assign pop            = words.rd_valid & words.rd_ready;
   assign words.wr_ready = (count != LEVEL_FULL);
   assign words.rd_valid = (count != LEVEL_EMPTY);
   assign words.rd_data  = entry[rd_ptr];
   assign words.level    = count;

   for (genvar i = 0; i < 2; i++) begin : g_entry
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            entry[i] <= '0;
         end else if (push && (wr_ptr == 1'(i))) begin
            entry[i] <= words.wr_data;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= LEVEL_EMPTY;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            count <= count + LEVEL_ONE;
         end else if (pop && !push) begin
            count <= count - LEVEL_ONE;
         end
      end
   end

endmodule : tx_word_buffer
`default_nettype wire

// file: rtl/async_serial_transmitter_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter_sampler
   import async_tx_pkg::*;
(
   // Clock and reset
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_N_I,
   // Configuration
   input  wire logic [DATA_W-1:0] BAUD_DIVISOR_I,
   input  wire logic              HIGH_SPEED_SELECT_I,
   input  wire logic              SYNC_MODE_SELECT_I,
   input  wire logic              SERIAL_PORT_ENABLE_I,
   input  wire logic              TRANSMIT_ENABLE_I,
   input  wire logic              NINE_BIT_TX_SELECT_I,
   input  wire logic              TX_NINTH_BIT_I,
   input  wire logic              SLEEP_I,
   // Transmit buffer write
   input  wire logic              TX_BUFFER_WRITE_I,
   input  wire logic [DATA_W-1:0] TX_BUFFER_DATA_I,
   output logic                   TX_BUFFER_READY_O,
   // Status
   output logic                   TX_BUFFER_EMPTY_FLAG_O,
   output logic                   SHIFT_REG_EMPTY_STATUS_O,
   // Serial pins
   output logic                   TRANSMIT_PIN_O,
   output logic                   TRANSMIT_PIN_OE_O,
   input  wire logic              RECEIVE_PIN_I,
   // Shared with the receiver
   output logic                   BAUD_TICK_O,
   output logic                   RX_SAMPLED_LEVEL_O,
   output logic                   RX_SAMPLE_STROBE_O
);

   // ---------------------------------------------------------------
   // Mode gating
   // ---------------------------------------------------------------
   logic              async_on;
   logic              run;
   logic              tx_on;

   assign async_on = SERIAL_PORT_ENABLE_I & ~SYNC_MODE_SELECT_I;
   assign run      = async_on & ~SLEEP_I;
   assign tx_on    = async_on & TRANSMIT_ENABLE_I;

   // ---------------------------------------------------------------
   // Baud generator
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] baud_count;
   logic              base_tick;
   logic [5:0]        last_phase;

   assign base_tick  = run && (baud_count == BAUD_RESET);
   assign last_phase = HIGH_SPEED_SELECT_I ? LAST_PHASE_FAST : LAST_PHASE_STD;

   // One tick every divisor plus one clocks; the same tick times both halves.
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         baud_count <= BAUD_RESET;
      end else if (!async_on) begin
         baud_count <= BAUD_RESET;
      end else if (run) begin
         baud_count <= base_tick ? BAUD_DIVISOR_I : baud_count - 8'h01;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         BAUD_TICK_O <= 1'b0;
      end else begin
         BAUD_TICK_O <= base_tick;
      end
   end

   // ---------------------------------------------------------------
   // Transmit bit timer
   // ---------------------------------------------------------------
   logic [5:0]        tx_phase;
   logic              tx_bit;

   assign tx_bit = base_tick && (tx_phase == last_phase);

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tx_phase <= 6'h00;
      end else if (!tx_on) begin
         tx_phase <= 6'h00;
      end else if (base_tick) begin
         tx_phase <= tx_bit ? 6'h00 : tx_phase + 6'h01;
      end
   end

   // ---------------------------------------------------------------
   // Transmit buffer
   // ---------------------------------------------------------------
   word_stream_if words ();

   logic              push;
   logic              pop;
   logic              drained;
   tx_state_t         state;

   assign words.wr_valid = TX_BUFFER_WRITE_I;
   assign words.wr_data  = {TX_NINTH_BIT_I, TX_BUFFER_DATA_I};
   assign TX_BUFFER_READY_O = words.wr_ready;
   assign push           = words.wr_valid & words.wr_ready;

   // The shift register takes a word only when idle or at a stop bit's end.
   assign words.rd_ready = tx_on && !SLEEP_I &&
                           ((state == TX_IDLE) || ((state == TX_STOP) && tx_bit));
   assign pop            = words.rd_valid & words.rd_ready;
   assign drained        = pop && !push && (words.level == LEVEL_ONE);

   tx_word_buffer u_buffer (
      .clk_i     (SYS_CLK_I),
      .reset_n_i (RESET_N_I),
      .words     (words.store)
   );

   // ---------------------------------------------------------------
   // Buffer empty flag
   // ---------------------------------------------------------------
   logic              enable_prev;
   logic              enable_rise;

   assign enable_rise = tx_on & ~enable_prev;

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         enable_prev <= 1'b0;
      end else begin
         enable_prev <= tx_on;
      end
   end

   // A set in the same cycle as a write wins, so no drain event is lost.
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         TX_BUFFER_EMPTY_FLAG_O <= FLAG_RESET;
      end else if (enable_rise || drained) begin
         TX_BUFFER_EMPTY_FLAG_O <= 1'b1;
      end else if (push) begin
         TX_BUFFER_EMPTY_FLAG_O <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Transmit sequencer
   // ---------------------------------------------------------------
   // The shift register has no port of its own toward software.
   logic [DATA_W-1:0] tx_shift_reg;
   logic              shift_ninth;
   logic              shift_nine_mode;
   logic [2:0]        bit_index;

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state <= TX_IDLE;
      end else if (!tx_on) begin
         state <= TX_IDLE;
      end else if (!SLEEP_I) begin
         unique case (state)
            TX_IDLE: begin
               if (pop) begin
                  state <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (tx_bit) begin
                  state <= TX_START;
               end
            end
            TX_START: begin
               if (tx_bit) begin
                  state <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit && (bit_index == LAST_DATA_BIT)) begin
                  state <= shift_nine_mode ? TX_NINTH : TX_STOP;
               end
            end
            TX_NINTH: begin
               if (tx_bit) begin
                  state <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit) begin
                  state <= pop ? TX_START : TX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tx_shift_reg    <= '0;
         shift_ninth     <= 1'b0;
         shift_nine_mode <= 1'b0;
      end else if (pop) begin
         tx_shift_reg    <= words.rd_data[DATA_W-1:0];
         shift_ninth     <= words.rd_data[NINTH_POS];
         shift_nine_mode <= NINE_BIT_TX_SELECT_I;
      end else if ((state == TX_DATA) && tx_bit) begin
         tx_shift_reg    <= {1'b0, tx_shift_reg[DATA_W-1:1]};
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         bit_index <= 3'h0;
      end else if (pop) begin
         bit_index <= 3'h0;
      end else if ((state == TX_DATA) && tx_bit) begin
         bit_index <= bit_index + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Transmit pin
   // ---------------------------------------------------------------
   logic              next_line;

   always_comb begin
      next_line = LINE_IDLE;
      unique case (state)
         TX_IDLE:  next_line = LINE_IDLE;
         TX_WAIT:  next_line = LINE_IDLE;
         TX_START: next_line = LINE_START;
         TX_DATA:  next_line = tx_shift_reg[0];
         TX_NINTH: next_line = shift_ninth;
         TX_STOP:  next_line = LINE_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         TRANSMIT_PIN_O    <= LINE_IDLE;
         TRANSMIT_PIN_OE_O <= 1'b0;
      end else begin
         TRANSMIT_PIN_O    <= tx_on ? next_line : LINE_IDLE;
         TRANSMIT_PIN_OE_O <= tx_on;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         SHIFT_REG_EMPTY_STATUS_O <= 1'b1;
      end else begin
         SHIFT_REG_EMPTY_STATUS_O <= (state == TX_IDLE) && !pop;
      end
   end

   // ---------------------------------------------------------------
   // Receive pin synchroniser and majority sampler
   // ---------------------------------------------------------------
   logic              rx_s1;
   logic              rx_s2;
   logic              rx_s3;
   logic              rx_level;
   logic              rx_level_prev;
   logic [5:0]        rx_phase;
   logic [1:0]        vote;
   logic [5:0]        pos_a;
   logic [5:0]        pos_b;
   logic [5:0]        pos_c;

   assign pos_a = HIGH_SPEED_SELECT_I ? SAMPLE_FAST_A : SAMPLE_STD_A;
   assign pos_b = HIGH_SPEED_SELECT_I ? SAMPLE_FAST_B : SAMPLE_STD_B;
   assign pos_c = HIGH_SPEED_SELECT_I ? SAMPLE_FAST_C : SAMPLE_STD_C;

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_s1    <= LINE_IDLE;
         rx_s2    <= LINE_IDLE;
         rx_s3    <= LINE_IDLE;
         rx_level <= LINE_IDLE;
      end else begin
         rx_s1 <= RECEIVE_PIN_I;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_level <= rx_s3;
         end
      end
   end

   // Each falling line edge is a bit boundary, so the phase realigns there.
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_level_prev <= LINE_IDLE;
         rx_phase      <= 6'h00;
      end else if (run) begin
         rx_level_prev <= rx_level;
         if (rx_level_prev && !rx_level) begin
            rx_phase <= 6'h00;
         end else if (base_tick) begin
            rx_phase <= (rx_phase == last_phase) ? 6'h00 : rx_phase + 6'h01;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         vote               <= 2'h0;
         RX_SAMPLED_LEVEL_O <= LINE_IDLE;
         RX_SAMPLE_STROBE_O <= 1'b0;
      end else begin
         RX_SAMPLE_STROBE_O <= 1'b0;
         if (base_tick && (rx_phase == pos_a)) begin
            vote[0] <= rx_level;
         end
         if (base_tick && (rx_phase == pos_b)) begin
            vote[1] <= rx_level;
         end
         if (base_tick && (rx_phase == pos_c)) begin
            RX_SAMPLED_LEVEL_O <= (vote[0] & vote[1]) | (vote[0] & rx_level) |
                                  (vote[1] & rx_level);
            RX_SAMPLE_STROBE_O <= 1'b1;
         end
      end
   end

endmodule : async_serial_transmitter_sampler
`default_nettype wire

// file: testbench/async_tx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module async_tx_properties
   import async_tx_pkg::*;
(
   // Clock and reset
   input wire logic              SYS_CLK_I,
   input wire logic              RESET_N_I,
   // Controls
   input wire logic [DATA_W-1:0] BAUD_DIVISOR_I,
   input wire logic              SYNC_MODE_SELECT_I,
   input wire logic              SERIAL_PORT_ENABLE_I,
   input wire logic              TRANSMIT_ENABLE_I,
   input wire logic              SLEEP_I,
   input wire logic              TX_BUFFER_WRITE_I,
   // Outputs watched
   input wire logic              TX_BUFFER_READY_O,
   input wire logic              TX_BUFFER_EMPTY_FLAG_O,
   input wire logic              SHIFT_REG_EMPTY_STATUS_O,
   input wire logic              TRANSMIT_PIN_O,
   input wire logic              TRANSMIT_PIN_OE_O,
   input wire logic              BAUD_TICK_O,
   input wire logic              RX_SAMPLED_LEVEL_O,
   input wire logic              RX_SAMPLE_STROBE_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   logic en;
   logic on;
   logic run;
   logic wr_ok;
   assign en    = SERIAL_PORT_ENABLE_I && !SYNC_MODE_SELECT_I && TRANSMIT_ENABLE_I;
   assign on    = en && !SLEEP_I;
   assign run   = SERIAL_PORT_ENABLE_I && !SYNC_MODE_SELECT_I && !SLEEP_I
                  && (BAUD_DIVISOR_I == 8'h01);
   assign wr_ok = TX_BUFFER_WRITE_I && TX_BUFFER_READY_O;

   chk_abort_release: assert property (!TRANSMIT_ENABLE_I |=> !TRANSMIT_PIN_OE_O && TRANSMIT_PIN_O)
      else $error("pin not released after enable low");
   chk_sync_off: assert property (SYNC_MODE_SELECT_I |=> !TRANSMIT_PIN_OE_O)
      else $error("pin driven in synchronous mode");
   chk_oe_driven: assert property (on |=> TRANSMIT_PIN_OE_O)
      else $error("pin not driven while enabled");
   chk_idle_high: assert property (SHIFT_REG_EMPTY_STATUS_O && $past(SHIFT_REG_EMPTY_STATUS_O) |-> TRANSMIT_PIN_O)
      else $error("line not high while idle");
   chk_flag_sticky: assert property (TX_BUFFER_EMPTY_FLAG_O && !wr_ok |=> TX_BUFFER_EMPTY_FLAG_O)
      else $error("empty flag cleared without a write");
   chk_write_clears: assert property (wr_ok && TX_BUFFER_EMPTY_FLAG_O && !SHIFT_REG_EMPTY_STATUS_O && on && $past(on) |=> !TX_BUFFER_EMPTY_FLAG_O)
      else $error("write did not clear empty flag");
   chk_move_at_once: assert property ((wr_ok && TX_BUFFER_EMPTY_FLAG_O && SHIFT_REG_EMPTY_STATUS_O && on && $past(on)) ##1 (on && !TX_BUFFER_WRITE_I) |-> !TX_BUFFER_EMPTY_FLAG_O ##1 (!SHIFT_REG_EMPTY_STATUS_O && TX_BUFFER_EMPTY_FLAG_O))
      else $error("word not moved to shift register in one cycle");
   chk_enable_flag: assert property ($rose(en) && !SLEEP_I |-> ##[1:2] TX_BUFFER_EMPTY_FLAG_O)
      else $error("enable did not set empty flag");
   chk_sleep_tick: assert property (SLEEP_I && $past(SLEEP_I) |-> !BAUD_TICK_O)
      else $error("baud tick during sleep");
   chk_tick_period: assert property (BAUD_TICK_O && run && $past(run) ##1 run |-> !BAUD_TICK_O ##1 BAUD_TICK_O)
      else $error("baud tick period wrong");
   chk_strobe_pulse: assert property (RX_SAMPLE_STROBE_O |=> !RX_SAMPLE_STROBE_O)
      else $error("sample strobe longer than one cycle");
   chk_level_hold: assert property (!RX_SAMPLE_STROBE_O |-> $stable(RX_SAMPLED_LEVEL_O))
      else $error("sampled level changed without strobe");

   cov_full: cover property (TX_BUFFER_WRITE_I && !TX_BUFFER_READY_O);
   cov_abort: cover property ($fell(TRANSMIT_PIN_OE_O));
   cov_low: cover property (RX_SAMPLE_STROBE_O && !RX_SAMPLED_LEVEL_O);
endmodule : async_tx_properties

bind async_serial_transmitter_sampler async_tx_properties chk_i (
   .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .BAUD_DIVISOR_I(BAUD_DIVISOR_I),
   .SYNC_MODE_SELECT_I(SYNC_MODE_SELECT_I), .SERIAL_PORT_ENABLE_I(SERIAL_PORT_ENABLE_I),
   .TRANSMIT_ENABLE_I(TRANSMIT_ENABLE_I), .SLEEP_I(SLEEP_I), .TX_BUFFER_WRITE_I(TX_BUFFER_WRITE_I),
   .TX_BUFFER_READY_O(TX_BUFFER_READY_O), .TX_BUFFER_EMPTY_FLAG_O(TX_BUFFER_EMPTY_FLAG_O),
   .SHIFT_REG_EMPTY_STATUS_O(SHIFT_REG_EMPTY_STATUS_O), .TRANSMIT_PIN_O(TRANSMIT_PIN_O),
   .TRANSMIT_PIN_OE_O(TRANSMIT_PIN_OE_O), .BAUD_TICK_O(BAUD_TICK_O),
   .RX_SAMPLED_LEVEL_O(RX_SAMPLED_LEVEL_O), .RX_SAMPLE_STROBE_O(RX_SAMPLE_STROBE_O));
`default_nettype wire

// file: testbench/serial_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
   // Clock and line
   input wire logic       clk_i,
   input wire logic       line_i,
   input wire logic       nine_i,
   input wire logic [7:0] bit_clks_i,
   // Frame to send on the receive pin
   input wire logic       send_i,
   input wire logic [7:0] send_data_i,
   // Decoded word, and the line driven onto the receive pin
   output var logic [8:0] word_o,
   output var logic       got_o,
   output var logic       rx_line_o
);
   initial begin : decode
      logic [8:0] w;
      got_o  = 1'b0;
      word_o = 9'h000;
      forever begin
         @(negedge line_i);
         w = 9'h000;
         repeat (bit_clks_i / 2) @(posedge clk_i);
         if (line_i === 1'b0) begin
            for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
               repeat (bit_clks_i) @(posedge clk_i);
               w[i] = line_i;
            end
            repeat (bit_clks_i) @(posedge clk_i);
            if (line_i === 1'b1) begin
               word_o <= w;
               got_o  <= 1'b1;
               @(posedge clk_i);
               got_o  <= 1'b0;
            end
         end
      end
   end

   initial begin : sender
      logic [9:0] f;
      rx_line_o = 1'b1;
      forever begin
         @(posedge send_i);
         f = {1'b1, send_data_i, 1'b0};
         for (int i = 0; i < 10; i++) begin
            rx_line_o <= f[i];
            repeat (bit_clks_i) @(posedge clk_i);
         end
      end
   end
endmodule : serial_peer_model
`default_nettype wire

// file: testbench/async_serial_transmitter_sampler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter_sampler_tb;
   import async_tx_pkg::*;
   logic       clk, rst_n, hs, sync, serial_port_enable, transmit_enable, nine, ninth, sleep, wr, send, full_seen;
   logic [7:0] div, wdata, sdata, bitc;
   logic       ready, flag, status, pin, oe, rxp, tick, lvl, strobe, got;
   logic [8:0] word;
   wire        tx_line;
   logic [8:0] exp_q[$];
   int         bad_count, n_checks, ticks;

   // The line carries a pull-up, so a released pin reads as idle.
   assign tx_line = (oe === 1'b1) ? pin : 1'b1;

   async_serial_transmitter_sampler uut (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .BAUD_DIVISOR_I(div), .HIGH_SPEED_SELECT_I(hs),
      .SYNC_MODE_SELECT_I(sync), .SERIAL_PORT_ENABLE_I(serial_port_enable), .TRANSMIT_ENABLE_I(transmit_enable),
      .NINE_BIT_TX_SELECT_I(nine), .TX_NINTH_BIT_I(ninth), .SLEEP_I(sleep),
      .TX_BUFFER_WRITE_I(wr), .TX_BUFFER_DATA_I(wdata), .TX_BUFFER_READY_O(ready),
      .TX_BUFFER_EMPTY_FLAG_O(flag), .SHIFT_REG_EMPTY_STATUS_O(status),
      .TRANSMIT_PIN_O(pin), .TRANSMIT_PIN_OE_O(oe), .RECEIVE_PIN_I(rxp),
      .BAUD_TICK_O(tick), .RX_SAMPLED_LEVEL_O(lvl), .RX_SAMPLE_STROBE_O(strobe));

   serial_peer_model peer (
      .clk_i(clk), .line_i(tx_line), .nine_i(nine), .bit_clks_i(bitc), .send_i(send),
      .send_data_i(sdata), .word_o(word), .got_o(got), .rx_line_o(rxp));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] seen);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic put(input logic [7:0] d, input logic n9);
      exp_q.push_back({n9 & nine, d});
      @(posedge clk);
      ninth <= n9;
      @(posedge clk);
      wr    <= 1'b1;
      wdata <= d;
      @(negedge clk);
      for (int k = 0; k < 2000 && ready !== 1'b1; k++) begin
         full_seen = 1'b1;
         @(negedge clk);
      end
      @(posedge clk);
      wr <= 1'b0;
   endtask : put

   task automatic drain();
      for (int k = 0; k < 9000 && exp_q.size() != 0; k++) @(posedge clk);
      repeat (bitc) @(posedge clk);
      @(negedge clk);
      chk("frames left", 9'h000, 9'(exp_q.size()));
   endtask : drain

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // ---------------------------------------------------------------
   // Clock, scoreboard and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin : monitor
      logic [8:0] want;
      if (got === 1'b1) begin
         if (exp_q.size() == 0) want = ~word;
         else want = exp_q.pop_front();
         chk("received word", want, word);
      end
   end

   initial begin : watchdog
      #4000000;
      bad_count++;
      close_out();
   end

   initial begin : main
      void'($urandom(32'h689bb2aa));
      {rst_n, sync, serial_port_enable, transmit_enable, nine, ninth, sleep, wr, send, full_seen} = '0;
      {wdata, sdata} = '0;
      div = 8'h01;
      hs = 1'b1;
      bitc = 8'h20;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("flag reset", 9'h000, flag);
      chk("status reset", 9'h001, status);
      chk("oe reset", 9'h000, oe);
      chk("ready reset", 9'h001, ready);
      @(posedge clk);
      serial_port_enable <= 1'b1;
      @(posedge clk);
      transmit_enable <= 1'b1;
      repeat (3) @(negedge clk);
      chk("flag on enable", 9'h001, flag);
      repeat (4) put(8'($urandom), 1'b0);
      drain();
      chk("buffer refused", 9'h001, full_seen);
      chk("flag after burst", 9'h001, flag);
      chk("status after burst", 9'h001, status);
      @(posedge clk);
      nine <= 1'b1;
      repeat (2) put(8'($urandom), 1'($urandom));
      drain();
      @(posedge clk);
      {transmit_enable, nine, hs, div, bitc} <= {3'h0, 8'h00, 8'h40};
      @(posedge clk);
      transmit_enable <= 1'b1;
      put(8'($urandom), 1'b0);
      drain();
      @(posedge clk);
      {transmit_enable, hs, div, bitc} <= {2'h1, 8'h01, 8'h20};
      @(posedge clk);
      transmit_enable <= 1'b1;
      put(8'hFF, 1'b0);
      repeat (100) @(posedge clk);
      transmit_enable <= 1'b0;
      repeat (3) @(negedge clk);
      chk("oe after abort", 9'h000, oe);
      chk("status after abort", 9'h001, status);
      @(posedge clk);
      transmit_enable <= 1'b1;
      drain();
      @(posedge clk);
      sleep <= 1'b1;
      ticks = 0;
      repeat (2) @(negedge clk);
      repeat (40) begin
         @(negedge clk);
         if (tick === 1'b1) ticks++;
      end
      chk("ticks in sleep", 9'h000, 9'(ticks));
      @(posedge clk);
      {sleep, sync} <= 2'h1;
      repeat (2) @(negedge clk);
      chk("oe in sync mode", 9'h000, oe);
      @(posedge clk);
      {sync, send, sdata} <= {2'h1, 8'h00};
      @(posedge clk);
      send <= 1'b0;
      for (int k = 0; k < 800 && !(strobe === 1'b1 && lvl === 1'b0); k++) @(negedge clk);
      chk("sampled low", 9'h000, lvl);
      repeat (400) @(negedge clk);
      chk("sampled high", 9'h001, lvl);
      @(posedge clk);
      {hs, div, bitc} <= {1'b0, 8'h00, 8'h40};
      @(posedge clk);
      send <= 1'b1;
      ticks = 0;
      @(posedge clk);
      send <= 1'b0;
      for (int k = 0; k < 800 && !(strobe === 1'b1 && lvl === 1'b0); k++) begin
         @(negedge clk);
         ticks++;
      end
      chk("std sampled low", 9'h000, lvl);
      chk("std sample time", 9'h001, 9'(ticks >= 30 && ticks <= 48));
      close_out();
   end
endmodule : async_serial_transmitter_sampler_tb
`default_nettype wire
